// *** hw/dxl_axil.sv ***
`timescale 1ns/1ps
`default_nettype none
// axi4-lite slave front end; register storage lives in the parent
module dxl_axil (
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic wr_en_o,
  output logic [7:0] wr_addr_o,
  output logic [31:0] wr_data_o,
  output logic [3:0] wr_strb_o,
  input wire logic wr_ok_i,
  output logic [7:0] rd_addr_o,
  input wire logic [31:0] rd_data_i,
  input wire logic rd_ok_i
);
  import dxl_pkg::*;
  logic aw_have_q;
  logic w_have_q;
  assign s_axi_awready = !aw_have_q && !s_axi_bvalid;
  assign s_axi_wready = !w_have_q && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign wr_en_o = aw_have_q && w_have_q;
  assign rd_addr_o = s_axi_araddr;
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      wr_addr_o <= 8'h00;
      wr_data_o <= 32'h0000_0000;
      wr_strb_o <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_q <= 1'b1;
        wr_addr_o <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_q <= 1'b1;
        wr_data_o <= s_axi_wdata;
        wr_strb_o <= s_axi_wstrb;
      end
      if (wr_en_o) begin
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
      end
    end
  end
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (wr_en_o) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_ok_i ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_ok_i ? rd_data_i : 32'h0000_0000;
      s_axi_rresp <= rd_ok_i ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule // dxl_axil
`default_nettype wire

// *** hw/dxl_fifo.sv ***
`timescale 1ns/1ps
`default_nettype none
module dxl_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 32
) (
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);
  initial begin
    if (DEPTH < 2 || (1 << AW) != DEPTH) begin
      $error("depth must be a power of two of at least two");
    end
  end
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW:0] wr_q;
  logic [AW:0] rd_q;
  logic full;
  logic empty;
  assign empty = (wr_q == rd_q);
  assign full = (wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]);
  assign in_ready_o = !full;
  assign out_valid_o = !empty;
  assign out_data_o = mem_q[rd_q[AW-1:0]];
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      wr_q <= '0;
    end else if (in_valid_i && !full) begin
      wr_q <= wr_q + 1'b1;
    end
  end
  always_ff @(posedge mclk_i) begin
    if (in_valid_i && !full) begin
      mem_q[wr_q[AW-1:0]] <= in_data_i;
    end
  end
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      rd_q <= '0;
    end else if (out_ready_i && !empty) begin
      rd_q <= rd_q + 1'b1;
    end
  end
endmodule // dxl_fifo
`default_nettype wire

// *** hw/dxl_line_ctrl.sv ***
`timescale 1ns/1ps
`default_nettype none
module dxl_line_ctrl #(
  parameter int LINE_PIXELS = 16,
  parameter int PIX_W = 8,
  parameter int FIFO_DEPTH = 32
) (
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic cam_ctrl1_i,
  input wire logic cam_ctrl3_i,
  input wire logic [PIX_W-1:0] upper_row_pix_i,
  input wire logic [PIX_W-1:0] lower_row_pix_i,
  output logic sensor_read_o,
  output logic line_start_o,
  output logic scan_reverse_o,
  output logic [15:0] upper_row_exp_o,
  output logic [15:0] lower_row_exp_o,
  output logic [15:0] upper_row_gain_o,
  output logic [15:0] lower_row_gain_o,
  output logic pix_valid_o,
  input wire logic pix_ready_i,
  output logic [PIX_W-1:0] pix_data_o,
  output logic pix_last_o
);
  import dxl_pkg::*;
  localparam int CW = $clog2(LINE_PIXELS);
  localparam logic [CW-1:0] LAST_PIX = CW'(LINE_PIXELS - 1);
  initial begin
    if (LINE_PIXELS < 2 || PIX_W > 16 || LINE_PIXELS > 4096) begin
      $error("line width or pixel width out of range");
    end
  end

  // ----------
  // pin synchronisers
  // ----------
  logic [1:0] cc1_sync_q;
  logic [1:0] cc3_sync_q;
  logic cc1_prev_q;
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      cc1_sync_q <= 2'b00;
      cc3_sync_q <= 2'b00;
      cc1_prev_q <= 1'b0;
    end else begin
      cc1_sync_q <= {cc1_sync_q[0], cam_ctrl1_i};
      cc3_sync_q <= {cc3_sync_q[0], cam_ctrl3_i};
      cc1_prev_q <= cc1_sync_q[1];
    end
  end

  // ----------
  // registers
  // ----------
  logic [31:0] ctrl_q;
  logic [15:0] exposure_q;
  logic [15:0] gain_q;
  logic [PIX_W-1:0] dark_offset_q;
  logic [15:0] exp_up_q;
  logic [15:0] exp_lo_q;
  logic [15:0] gain_up_q;
  logic [15:0] gain_lo_q;
  logic [31:0] window_q;
  logic [31:0] cal_roi_q;
  logic [7:0] cal_target_q;
  logic [15:0] period_q;
  logic wr_en;
  logic [7:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic [7:0] rd_addr;
  logic [31:0] rd_data;
  logic wr_ok;
  logic rd_ok;
  logic busy_q;
  logic fifo_overflow_q;

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[8*i +: 8] = nw[8*i +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic known(input logic [7:0] a);
    return a <= ADDR_STATUS && a[1:0] == 2'b00;
  endfunction

  dxl_axil u_axil (
    .mclk_i(mclk_i),
    .sys_rst_i(sys_rst_i),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .wr_en_o(wr_en),
    .wr_addr_o(wr_addr),
    .wr_data_o(wr_data),
    .wr_strb_o(wr_strb),
    .wr_ok_i(wr_ok),
    .rd_addr_o(rd_addr),
    .rd_data_i(rd_data),
    .rd_ok_i(rd_ok)
  );

  assign wr_ok = known(wr_addr);
  assign rd_ok = known(rd_addr);

  logic [31:0] wv;
  assign wv = merge(32'h0000_0000, wr_data, wr_strb);

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      ctrl_q <= CTRL_RESET;
      exposure_q <= EXP_RESET;
      gain_q <= GAIN_RESET;
      dark_offset_q <= '0;
      window_q <= 32'h0000_0000;
      cal_roi_q <= 32'h0000_0000;
      cal_target_q <= 8'h00;
      period_q <= PERIOD_RESET;
    end else if (wr_en) begin
      case (wr_addr)
        ADDR_CTRL: ctrl_q <= merge(ctrl_q, wr_data, wr_strb);
        ADDR_EXPOSURE: exposure_q <= wr_data[15:0];
        ADDR_GAIN: gain_q <= wr_data[15:0];
        ADDR_DARK: dark_offset_q <= wr_data[PIX_W-1:0];
        ADDR_WINDOW: window_q <= merge(window_q, wr_data, wr_strb);
        ADDR_CAL_ROI: cal_roi_q <= merge(cal_roi_q, wr_data, wr_strb);
        ADDR_CAL_TGT: cal_target_q <= wr_data[7:0];
        ADDR_PERIOD: period_q <= wr_data[15:0];
        // external trigger origin and trigger action are fixed: writes fall through
        // read-only trigger codes
        default: ;
      endcase
    end
  end

  logic [1:0] exp_row;
  logic [1:0] gain_row;
  assign exp_row = ctrl_q[CTRL_EXP_ROW +: 2];
  assign gain_row = ctrl_q[CTRL_GAIN_ROW +: 2];

  // ----------
  // per-row exposure and gain
  // ----------
  // writing the shared value spreads it by the row choice
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      exp_up_q <= EXP_RESET;
      exp_lo_q <= EXP_RESET;
    end else if (wr_en && wr_addr == ADDR_EXPOSURE) begin
      if (exp_row != ROW_LOWER) exp_up_q <= wv[15:0];
      if (exp_row != ROW_UPPER) exp_lo_q <= wv[15:0];
    end else if (wr_en && wr_addr == ADDR_EXP_UP) begin
      exp_up_q <= wv[15:0];
    end else if (wr_en && wr_addr == ADDR_EXP_LO) begin
      exp_lo_q <= wv[15:0];
    end
  end

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      gain_up_q <= GAIN_RESET;
      gain_lo_q <= GAIN_RESET;
    end else if (wr_en && wr_addr == ADDR_GAIN) begin
      if (gain_row != ROW_LOWER) gain_up_q <= wv[15:0];
      if (gain_row != ROW_UPPER) gain_lo_q <= wv[15:0];
    end else if (wr_en && wr_addr == ADDR_GAIN_UP) begin
      gain_up_q <= wv[15:0];
    end else if (wr_en && wr_addr == ADDR_GAIN_LO) begin
      gain_lo_q <= wv[15:0];
    end
  end

  logic dual;
  logic cal;
  assign dual = ctrl_q[CTRL_DUAL];
  assign cal = ctrl_q[CTRL_CAL] && dual;

  // calibration itself never overwrites the stored row values, so clearing
  // the calibrate bit brings every row back to its own settings
  // common calibration exposure and gain
  assign upper_row_exp_o = cal ? exposure_q : exp_up_q;
  assign lower_row_exp_o = cal ? exposure_q : exp_lo_q;
  assign upper_row_gain_o = cal ? gain_q : gain_up_q;
  assign lower_row_gain_o = cal ? gain_q : gain_lo_q;

  // ----------
  // scan direction and trigger origin
  // ----------
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      scan_reverse_o <= 1'b0;
    end else if (ctrl_q[CTRL_DIR_ORIGIN]) begin
      scan_reverse_o <= cc3_sync_q[1];
    end else begin
      scan_reverse_o <= ctrl_q[CTRL_DIR_SETTING];
    end
  end

  logic [15:0] longest_exp;
  logic [15:0] period_eff;
  logic [15:0] period_cnt_q;
  logic int_trig;
  logic ext_trig;
  logic trigger;
  assign longest_exp = (exp_up_q > exp_lo_q) ? exp_up_q : exp_lo_q;
  assign period_eff = (dual && longest_exp > period_q) ? longest_exp
                                                        : period_q;
  assign int_trig = (period_cnt_q == 16'h0000);
  assign ext_trig = cc1_sync_q[1] && !cc1_prev_q;
  assign trigger = ctrl_q[CTRL_ENABLE] &&
                   (ctrl_q[CTRL_TRIG_ORIGIN] ? ext_trig : int_trig);

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i || !ctrl_q[CTRL_ENABLE]) begin
      period_cnt_q <= PERIOD_RESET;
    end else if (int_trig) begin
      period_cnt_q <= period_eff;
    end else begin
      period_cnt_q <= period_cnt_q - 16'h0001;
    end
  end

  // ----------
  // line readout: lower half then upper half in dual mode
  // ----------
  typedef enum logic [1:0] {
    RD_IDLE = 2'b00,
    RD_LOWER = 2'b01,
    RD_UPPER = 2'b10
  } dxl_rd_t;
  dxl_rd_t rd_state_q;
  logic [CW-1:0] pix_cnt_q;
  logic fifo_ready;
  logic [15:0] win_start;
  logic [15:0] win_end;
  logic in_window;
  logic take;
  assign win_start = window_q[15:0];
  assign win_end = window_q[31:16];
  assign in_window = (win_end == 16'h0000) ||
                     ({4'h0, 12'(pix_cnt_q)} >= win_start &&
                      {4'h0, 12'(pix_cnt_q)} <= win_end);
  assign take = (rd_state_q != RD_IDLE) && fifo_ready;
  assign sensor_read_o = take;
  assign busy_q = (rd_state_q != RD_IDLE);

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      rd_state_q <= RD_IDLE;
      pix_cnt_q <= '0;
      line_start_o <= 1'b0;
      fifo_overflow_q <= 1'b0;
    end else begin
      line_start_o <= 1'b0;
      case (rd_state_q)
        RD_IDLE: begin
          if (trigger) begin
            rd_state_q <= dual ? RD_LOWER : RD_UPPER;
            pix_cnt_q <= '0;
            line_start_o <= 1'b1;
          end
        end
        RD_LOWER, RD_UPPER: begin
          if (trigger) fifo_overflow_q <= 1'b1;
          if (take) begin
            pix_cnt_q <= pix_cnt_q + 1'b1;
            if (pix_cnt_q == LAST_PIX) begin
              pix_cnt_q <= '0;
              rd_state_q <= (rd_state_q == RD_LOWER) ? RD_UPPER : RD_IDLE;
            end
          end
        end
        default: rd_state_q <= RD_IDLE;
      endcase
    end
  end

  logic [PIX_W-1:0] raw_pix;
  logic [PIX_W:0] sum;
  logic [PIX_W-1:0] out_pix;
  logic last;
  assign raw_pix = (rd_state_q == RD_LOWER) ? lower_row_pix_i
                                            : upper_row_pix_i;
  assign sum = {1'b0, raw_pix} + {1'b0, dark_offset_q};
  assign out_pix = sum[PIX_W] ? {PIX_W{1'b1}} : sum[PIX_W-1:0];
  assign last = (rd_state_q == RD_UPPER) && (pix_cnt_q == LAST_PIX);

  // one calibration roi for both rows, read back by software
  dxl_fifo #(
    .WIDTH(PIX_W + 1),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .mclk_i(mclk_i),
    .sys_rst_i(sys_rst_i),
    .in_valid_i(take && (in_window || last)),
    .in_ready_o(fifo_ready),
    .in_data_i({last, out_pix}),
    .out_valid_o(pix_valid_o),
    .out_ready_i(pix_ready_i),
    .out_data_o({pix_last_o, pix_data_o})
  );

  always_comb begin
    case (rd_addr)
      ADDR_CTRL: rd_data = ctrl_q;
      ADDR_EXPOSURE: rd_data = {16'h0000, exposure_q};
      ADDR_GAIN: rd_data = {16'h0000, gain_q};
      ADDR_DARK: rd_data = 32'(dark_offset_q);
      ADDR_EXP_UP: rd_data = {16'h0000, exp_up_q};
      ADDR_EXP_LO: rd_data = {16'h0000, exp_lo_q};
      ADDR_GAIN_UP: rd_data = {16'h0000, gain_up_q};
      ADDR_GAIN_LO: rd_data = {16'h0000, gain_lo_q};
      ADDR_WINDOW: rd_data = window_q;
      ADDR_CAL_ROI: rd_data = cal_roi_q;
      ADDR_CAL_TGT: rd_data = {24'h000000, cal_target_q};
      ADDR_PERIOD: rd_data = {16'h0000, period_q};
      ADDR_TRIG_RO: rd_data = {24'h000000, TRIGGER_ACTION_CHOICE,
                               EXT_TRIGGER_ORIGIN};
      ADDR_STATUS: rd_data = {28'h0000000, fifo_overflow_q, cal,
                              scan_reverse_o, busy_q};
      default: rd_data = 32'h0000_0000;
    endcase
  end
endmodule // dxl_line_ctrl
`default_nettype wire

// *** hw/dxl_pkg.sv ***
// Functional notes
// - exposure row choice: both rows, upper row only, or lower row only.
// - internal scan origin: direction comes from the stored direction setting.
// - external scan origin: direction follows the level on control input three.
// - gain row choice routes gain to both rows, upper only, or lower only.
// - dark offset is added to every output pixel in digital number units.
// - calibration in dual mode forces one common integration time on both rows.
// - after calibration each row's exposure and gain return to prior values.
// - calibration region of interest uses identical coordinates on both rows.
// - dual mode line is twice as wide: same scene line, two exposures.
// - lower row pixels fill the left half, upper row pixels the right half.
// - one output window applies identically to upper and lower row data; the code always passes the last upper row pixel, even outside the window.
// - dual mode caps line rate by the longer of the two exposures; the code caps only the internal trigger period.
// - trigger origin choice: internal generator or control input one.
// - external trigger origin and trigger action read back, writes ignored.
package dxl_pkg;
  // ----------
  // register byte addresses
  // ----------
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_EXPOSURE = 8'h04;
  localparam logic [7:0] ADDR_GAIN = 8'h08;
  localparam logic [7:0] ADDR_DARK = 8'h0C;
  localparam logic [7:0] ADDR_EXP_UP = 8'h10;
  localparam logic [7:0] ADDR_EXP_LO = 8'h14;
  localparam logic [7:0] ADDR_GAIN_UP = 8'h18;
  localparam logic [7:0] ADDR_GAIN_LO = 8'h1C;
  localparam logic [7:0] ADDR_WINDOW = 8'h20;
  localparam logic [7:0] ADDR_CAL_ROI = 8'h24;
  localparam logic [7:0] ADDR_CAL_TGT = 8'h28;
  localparam logic [7:0] ADDR_PERIOD = 8'h2C;
  localparam logic [7:0] ADDR_TRIG_RO = 8'h30;
  localparam logic [7:0] ADDR_STATUS = 8'h34;
  // ----------
  // control register fields
  // ----------
  localparam int CTRL_EXP_ROW = 0;
  localparam int CTRL_GAIN_ROW = 2;
  localparam int CTRL_DIR_ORIGIN = 4;
  localparam int CTRL_DIR_SETTING = 5;
  localparam int CTRL_TRIG_ORIGIN = 6;
  localparam int CTRL_DUAL = 7;
  localparam int CTRL_CAL = 8;
  localparam int CTRL_ENABLE = 9;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  // ----------
  // row choices and fixed read-only codes
  // ----------
  typedef enum logic [1:0] {
    ROW_BOTH = 2'b00,
    ROW_UPPER = 2'b01,
    ROW_LOWER = 2'b10
  } dxl_row_t;
  localparam logic [3:0] EXT_TRIGGER_ORIGIN = 4'h1;
  localparam logic [3:0] TRIGGER_ACTION_CHOICE = 4'h2;
  localparam logic [15:0] EXP_RESET = 16'h0064;
  localparam logic [15:0] GAIN_RESET = 16'h0100;
  localparam logic [15:0] PERIOD_RESET = 16'h00C8;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage

// *** testbench/dxl_host_sink.sv ***
`timescale 1ns/1ps
`default_nettype none
// mode 0 always ready, 1 every other cycle, 2 stalled
module dxl_host_sink #(
  parameter int PIX_W = 8
) (
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  input wire logic clear_i,
  input wire logic [1:0] mode_i,
  input wire logic pix_valid_i,
  input wire logic [PIX_W-1:0] pix_data_i,
  input wire logic pix_last_i,
  output logic pix_ready_o
);
  logic [PIX_W-1:0] seen_q [64];
  int n_seen;
  logic line_done;
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i || mode_i == 2'h2) pix_ready_o <= 1'b0;
    else pix_ready_o <= (mode_i == 2'h0) | !pix_ready_o;
  end
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i || clear_i) begin
      n_seen <= 0;
      line_done <= 1'b0;
    end else if (pix_valid_i && pix_ready_o && n_seen < 64) begin
      seen_q[n_seen] <= pix_data_i;
      n_seen <= n_seen + 1;
      line_done <= pix_last_i;
    end
  end
endmodule // dxl_host_sink
`default_nettype wire

// *** testbench/dxl_line_ctrl_asserts.sv ***
`timescale 1ns/1ps
`default_nettype none
module dxl_line_ctrl_chk #(
  parameter int LINE_PIXELS = 16,
  parameter int PIX_W = 8
) (
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic line_start_o,
  input wire logic [15:0] upper_row_exp_o,
  input wire logic [15:0] lower_row_exp_o,
  input wire logic pix_valid_o,
  input wire logic pix_ready_i,
  input wire logic [PIX_W-1:0] pix_data_o,
  input wire logic pix_last_o
);
  logic [2:0] wr_age_q;
  logic [6:0] pix_cnt_q;
  // exposures may only move shortly after a register write
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i || (s_axi_wvalid && s_axi_wready)) wr_age_q <= 3'h0;
    else if (wr_age_q != 3'h7) wr_age_q <= wr_age_q + 3'h1;
  end
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) pix_cnt_q <= 7'h00;
    else if (pix_valid_o && pix_ready_i)
      pix_cnt_q <= pix_last_o ? 7'h00 : pix_cnt_q + 7'h01;
  end
  default clocking @(posedge mclk_i); endclocking
  default disable iff (sys_rst_i);
  rst_idle_a: assert property (disable iff (1'b0) sys_rst_i |=>
    !s_axi_bvalid && !s_axi_rvalid && !pix_valid_o && !line_start_o)
    else $error("outputs busy after reset");
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer dropped");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read answer dropped");
  read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=>
    s_axi_rvalid) else $error("read answer late");
  pix_hold_a: assert property (
    pix_valid_o && !pix_ready_i |=> pix_valid_o && $stable(pix_data_o)
    && $stable(pix_last_o)) else $error("pixel changed while stalled");
  start_pulse_a: assert property (
    line_start_o |=> !line_start_o) else $error("line start too long");
  exp_cause_a: assert property (
    $changed(upper_row_exp_o) || $changed(lower_row_exp_o) |->
    wr_age_q < 3'h6) else $error("exposure moved without write");
  line_len_a: assert property (
    pix_valid_o && pix_ready_i && pix_last_o |->
    pix_cnt_q < 2 * LINE_PIXELS) else $error("line too long");
  cover property (pix_last_o && pix_ready_i && pix_valid_o
    && pix_cnt_q == 7'h1F);
  cover property (pix_valid_o && !pix_ready_i [*3]);
  cover property (s_axi_rvalid && s_axi_rready);
endmodule // dxl_line_ctrl_chk
bind dxl_line_ctrl dxl_line_ctrl_chk #(.LINE_PIXELS(LINE_PIXELS),
  .PIX_W(PIX_W)) dxl_line_ctrl_chk_i (.*);
`default_nettype wire

// *** testbench/tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import dxl_pkg::*;
  localparam int LP = 16;
  logic mclk_i = 1'b0, sys_rst_i = 1'b1, clr = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd_val;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic cam_ctrl1_i = 1'b0, cam_ctrl3_i = 1'b0;
  logic [7:0] upper_row_pix_i = 8'h50, lower_row_pix_i = 8'h20, pix_data_o;
  logic [1:0] mode = 2'h0, s_axi_bresp, s_axi_rresp, lresp;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, sensor_read_o, line_start_o, scan_reverse_o;
  logic pix_valid_o, pix_ready_i, pix_last_o;
  logic [15:0] upper_row_exp_o, lower_row_exp_o;
  logic [15:0] upper_row_gain_o, lower_row_gain_o;
  int n_mismatch = 0, n_compared = 0, cyc = 0;
  always #10 mclk_i = ~mclk_i;
  dxl_line_ctrl #(.LINE_PIXELS(LP)) dxl_line_ctrl_i (.*);
  dxl_host_sink dxl_host_sink_i (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i),
    .clear_i(clr), .mode_i(mode), .pix_valid_i(pix_valid_o),
    .pix_data_i(pix_data_o), .pix_last_i(pix_last_o),
    .pix_ready_o(pix_ready_i));
  // ----------
  // shared tasks
  // ----------
  task automatic chk(input logic [31:0] seen, input logic [31:0] want);
    n_compared++;
    if (seen !== want) begin
      n_mismatch++;
      $display("unexpected at %0t: %h, expected %h", $time, seen, want);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ta, tw;
    ta = 1'b0;
    tw = 1'b0;
    @(posedge mclk_i);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(ta && tw)) begin
      @(negedge mclk_i);
      ta = ta | (s_axi_awvalid & s_axi_awready);
      tw = tw | (s_axi_wvalid & s_axi_wready);
      @(posedge mclk_i);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
    end
    do @(negedge mclk_i); while (!s_axi_bvalid);
    lresp = s_axi_bresp;
    @(posedge mclk_i);
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge mclk_i);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(negedge mclk_i); while (!s_axi_arready);
    @(posedge mclk_i);
    s_axi_arvalid <= 1'b0;
    do @(negedge mclk_i); while (!s_axi_rvalid);
    rd_val = s_axi_rdata;
    lresp = s_axi_rresp;
    @(posedge mclk_i);
    s_axi_rready <= 1'b0;
  endtask
  task automatic host_clr();
    @(posedge mclk_i);
    clr <= 1'b1;
    @(posedge mclk_i);
    clr <= 1'b0;
  endtask
  task automatic wait_last();
    for (int k = 0; k < 800 && !dxl_host_sink_i.line_done; k++)
      @(posedge mclk_i);
    chk({31'h0, dxl_host_sink_i.line_done}, 32'h1);
  endtask
  task automatic pulse();
    @(posedge mclk_i);
    cam_ctrl1_i <= 1'b1;
    repeat (4) @(posedge mclk_i);
    cam_ctrl1_i <= 1'b0;
  endtask
  // ----------
  // scenarios
  // ----------
  task automatic t_regs();
    logic [31:0] ro;
    chk({upper_row_exp_o, lower_row_gain_o}, {EXP_RESET, GAIN_RESET});
    rd(ADDR_CTRL);
    chk(rd_val, CTRL_RESET);
    rd(ADDR_TRIG_RO);
    ro = rd_val;
    wr(ADDR_TRIG_RO, 32'hFFFF_FFFF);
    chk({30'h0, lresp}, {30'h0, RESP_OKAY});
    rd(ADDR_TRIG_RO);
    chk(rd_val, ro);
    rd(8'h40);
    chk({rd_val[29:0], lresp}, {30'h0, RESP_SLVERR});
  endtask
  task automatic t_rows();
    logic [15:0] eu, el, v;
    dxl_row_t r;
    eu = EXP_RESET;
    el = EXP_RESET;
    for (int i = 0; i < 3; i++) begin
      r = dxl_row_t'(2 - i);
      v = 16'h0200 + 16'(i);
      wr(ADDR_CTRL, {28'h0, r, r});
      wr(ADDR_EXPOSURE, {16'h0, v});
      if (i != 0) eu = v;
      if (i != 1) el = v;
      chk({upper_row_exp_o, lower_row_exp_o}, {eu, el});
      wr(ADDR_GAIN, {16'h0, v});
      chk({upper_row_gain_o, lower_row_gain_o},
        {(i == 0) ? GAIN_RESET : v, (i == 1) ? 16'h0200 : v});
    end
  endtask
  task automatic t_dir();
    for (int i = 0; i < 2; i++) begin
      wr(ADDR_CTRL, 32'(i) << CTRL_DIR_SETTING);
      repeat (3) @(posedge mclk_i);
      chk({31'h0, scan_reverse_o}, 32'(i));
      cam_ctrl3_i <= i[0];
      wr(ADDR_CTRL, 32'h10 | (32'(1 - i) << CTRL_DIR_SETTING));
      repeat (5) @(posedge mclk_i);
      chk({31'h0, scan_reverse_o}, 32'(i));
    end
  endtask
  task automatic t_line();
    host_clr();
    wr(ADDR_DARK, 32'h0000_00C0);
    wr(ADDR_CTRL, 32'h1 << CTRL_ENABLE);
    wait_last();
    chk(32'(dxl_host_sink_i.n_seen), 32'(LP));
    chk({24'h0, dxl_host_sink_i.seen_q[0]}, 32'h0000_00FF);
    wr(ADDR_CTRL, 32'h0000_0240);
    repeat (60) @(posedge mclk_i);
    host_clr();
    repeat (400) @(posedge mclk_i);
    chk(32'(dxl_host_sink_i.n_seen), 32'h0);
  endtask
  task automatic t_cal();
    wr(ADDR_CTRL, 32'h1 << CTRL_DUAL);
    wr(ADDR_EXPOSURE, 32'h0000_0333);
    wr(ADDR_EXP_UP, 32'h0000_0111);
    wr(ADDR_EXP_LO, 32'h0000_0222);
    wr(ADDR_CTRL, 32'h0000_0180);
    chk({upper_row_exp_o, lower_row_exp_o}, 32'h0333_0333);
    wr(ADDR_CTRL, 32'h1 << CTRL_DUAL);
    chk({upper_row_exp_o, lower_row_exp_o}, 32'h0111_0222);
  endtask
  task automatic t_dual();
    wr(ADDR_DARK, 32'h0000_0005);
    wr(ADDR_EXP_UP, 32'h0000_0100);
    wr(ADDR_EXP_LO, 32'h0000_0040);
    wr(ADDR_CTRL, 32'h0000_02C0);
    host_clr();
    mode <= 2'h2;
    pulse();
    pulse();
    mode <= 2'h1;
    wait_last();
    repeat (100) @(posedge mclk_i);
    chk(32'(dxl_host_sink_i.n_seen), 32'(2 * LP));
    for (int k = 0; k < LP; k++) begin
      chk({24'h0, dxl_host_sink_i.seen_q[k]}, 32'h25);
      chk({24'h0, dxl_host_sink_i.seen_q[LP + k]}, 32'h55);
    end
    rd(ADDR_STATUS);
    chk({31'h0, rd_val[3]}, 32'h1);
  endtask
  task automatic summarize();
    if (n_mismatch == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  always @(posedge mclk_i) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      summarize();
    end
  end
  initial begin
    repeat (12) @(posedge mclk_i);
    sys_rst_i <= 1'b0;
    t_regs();
    t_rows();
    t_dir();
    t_line();
    t_cal();
    t_dual();
    summarize();
  end
endmodule // tb_top
`default_nettype wire
